/* logic/pob_output_config_bank.sv */
`timescale 1ns/1ns

// What this block does
// - code 21h is a 16-bit read/write unsigned nominal output setpoint.
// - code 22h holds signed trim, same exponent, added while trim enabled.
// - code 23h holds signed calibration, applied in linear output format.
// - code 24h caps setpoint; writes above 110% of strap value are clamped to it.
// - code 25h holds the output target used while margining high.
// - code 26h holds the output target used while margining low.
// - code 27h sets slew rate of output reference changes per millisecond.
// - code 28h holds the droop load-line slope.
// - code 29h holds the sense converter loop gain, direct format.
// - code 2Ah holds the monitor divider scale factor, direct format.
// - code 32h holds the maximum duty-cycle limit in percent.
// - code 33h holds the switching frequency in 1 kHz steps.
// - code 35h is input level at which conversion starts.
// - code 36h is input level at which running conversion stops.
// - code 37h packs group 11:8, unit count 7:4, position 3:0.
// - code 39h is word read only; offset added to current readings.
// - code 40h holds the unsigned output over-voltage fault threshold.
// - code 41h is a read/write byte choosing over-voltage reaction.
// - format bits 7:5 select number format; 4:0 signed exponent.
module pob_output_config_bank
    import pob_pkg::*;
#(
    parameter int TICK_CYC = SLEW_TICK_CYC
) (
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    // command port from the bus engine
    input  wire pob_cmd_s  cmd_i,
    output pob_rsp_s       rsp_o,
    // converter side inputs
    input  wire pob_word_t strap_vout_i,
    input  wire logic      trim_en_i,
    input  wire logic [1:0] margin_i,
    input  wire pob_word_t vin_i,
    input  wire pob_word_t vout_meas_i,
    input  wire pob_word_t iout_raw_i,
    // converter side outputs
    output pob_word_t      vout_ref_o,
    output pob_word_t      iout_corr_o,
    output logic           conv_run_o,
    output logic           ov_fault_o,
    output logic [7:0]     ov_reaction_o,
    output pob_word_t      droop_o,
    output pob_word_t      loop_gain_o,
    output pob_word_t      mon_scale_o,
    output pob_word_t      duty_limit_o,
    output pob_word_t      fsw_o,
    output logic [3:0]     phase_group_o,
    output logic [3:0]     phase_count_o,
    output logic [3:0]     phase_pos_o
);

    // ==========================================================
    // command decode
    function automatic pob_dec_s decode(input pob_code_t code);
        pob_dec_s r;
        r = '{hit: 1'b1, idx: IDX_SETPOINT, is_byte: 1'b0,
              read_only: 1'b0};
        case (code)
            CMD_OUTPUT_SETPOINT:        r.idx = IDX_SETPOINT;
            CMD_OUTPUT_TRIM:            r.idx = IDX_TRIM;
            CMD_OUTPUT_CALIBRATION:     r.idx = IDX_CAL;
            CMD_OUTPUT_UPPER_BOUND:     r.idx = IDX_UPPER;
            CMD_MARGIN_UP_TARGET:       r.idx = IDX_MARGIN_UP;
            CMD_MARGIN_DOWN_TARGET:     r.idx = IDX_MARGIN_DN;
            CMD_OUTPUT_SLEW_RATE:       r.idx = IDX_SLEW;
            CMD_LOAD_LINE_SLOPE:        r.idx = IDX_DROOP;
            CMD_SENSE_LOOP_GAIN:        r.idx = IDX_LOOP_GAIN;
            CMD_MONITOR_DIVIDER_SCALE:  r.idx = IDX_MON_SCALE;
            CMD_DUTY_CYCLE_LIMIT:       r.idx = IDX_DUTY;
            CMD_SWITCHING_RATE:         r.idx = IDX_FSW;
            CMD_INPUT_START_THRESHOLD:  r.idx = IDX_VIN_START;
            CMD_INPUT_STOP_THRESHOLD:   r.idx = IDX_VIN_STOP;
            CMD_PHASE_SPREAD_CONFIG:    r.idx = IDX_PHASE;
            CMD_CURRENT_READING_OFFSET: begin
                r.idx       = IDX_IOUT_OFS;
                r.read_only = 1'b1;
            end
            CMD_OVERVOLTAGE_THRESHOLD:  r.idx = IDX_OV_LIMIT;
            CMD_OVERVOLTAGE_REACTION:   r.is_byte = 1'b1;
            default:                    r.hit = 1'b0;
        endcase
        return r;
    endfunction

    // ==========================================================
    // state
    typedef struct packed {
        pob_word_t [NUM_WORDS-1:0] words;
        logic [7:0]  reaction;
        pob_word_t   strap_s1;
        pob_word_t   strap_s2;
        pob_word_t   strap;
        logic [1:0]  strap_cnt;
        logic        strap_ok;
        logic [31:0] tick_cnt;
        logic        tick;
        pob_word_t   vref;
        pob_word_t   iout_corr;
        logic        run;
        logic        ov;
        pob_rsp_s    rsp;
    } pob_state_s;

    pob_state_s q, d;
    pob_dec_s   dec;
    pob_word_t  bound;
    pob_word_t  base;
    pob_word_t  target;
    pob_word_t  step;
    logic [31:0] bound_wide;
    logic [17:0] sum;

    // ==========================================================
    // datapath helpers
    always_comb begin
        bound_wide = (32'(q.strap) * 32'(BOUND_NUM)) / 32'(BOUND_DEN);
        if (bound_wide > 32'h0000ffff) begin
            bound = 16'hffff;
        end else begin
            bound = bound_wide[15:0];
        end
        dec = decode(cmd_i.code);
        case (margin_i)
            MARGIN_UP:   base = q.words[IDX_MARGIN_UP];
            MARGIN_DOWN: base = q.words[IDX_MARGIN_DN];
            default:     base = q.words[IDX_SETPOINT];
        endcase
        sum = {2'b00, base};
        if (trim_en_i) begin
            sum = sum + {{2{q.words[IDX_TRIM][15]}},
                         q.words[IDX_TRIM]};
        end
        if (OUT_FORMAT[7:FMT_SEL_LSB] == FMT_LINEAR) begin
            sum = sum + {{2{q.words[IDX_CAL][15]}},
                         q.words[IDX_CAL]};
        end
        if (sum[17]) begin
            target = 16'h0000;
        end else if (sum[16] || sum[15:0] > q.words[IDX_UPPER]) begin
            target = q.words[IDX_UPPER];
        end else begin
            target = sum[15:0];
        end
        step = q.words[IDX_SLEW];
    end

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        d.rsp.valid = 1'b0;
        d.rsp.err   = 1'b0;

        // strap capture after release of reset
        d.strap_s1 = strap_vout_i;
        d.strap_s2 = q.strap_s1;
        if (!q.strap_ok) begin
            if (q.strap_cnt == STRAP_SETTLE) begin
                d.strap    = q.strap_s2;
                d.strap_ok = 1'b1;
            end else begin
                d.strap_cnt = q.strap_cnt + 2'h1;
            end
        end

        // millisecond tick for the slew limiter
        d.tick = 1'b0;
        if (q.tick_cnt == 32'(TICK_CYC - 1)) begin
            d.tick_cnt = 32'h0;
            d.tick     = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 32'h1;
        end

        // command handling
        if (cmd_i.valid) begin
            d.rsp.valid = 1'b1;
            if (!dec.hit || dec.is_byte == cmd_i.word) begin
                d.rsp.err = 1'b1;
            end else if (cmd_i.write) begin
                if (dec.read_only) begin
                    d.rsp.err = 1'b1;
                end else if (dec.is_byte) begin
                    d.reaction = cmd_i.data[7:0];
                end else if (dec.idx == IDX_UPPER) begin
                    if (cmd_i.data > bound) begin
                        d.words[IDX_UPPER] = bound;
                    end else begin
                        d.words[IDX_UPPER] = cmd_i.data;
                    end
                end else if (dec.idx == IDX_PHASE) begin
                    d.words[IDX_PHASE] = cmd_i.data & PHASE_MASK;
                end else begin
                    d.words[dec.idx] = cmd_i.data;
                end
            end else if (dec.is_byte) begin
                d.rsp.data = {8'h00, q.reaction};
            end else begin
                d.rsp.data = q.words[dec.idx];
            end
        end

        // output reference slews toward the target
        if (step == 16'h0000) begin
            d.vref = target;
        end else if (q.tick) begin
            if (target > q.vref) begin
                if (target - q.vref > step) begin
                    d.vref = q.vref + step;
                end else begin
                    d.vref = target;
                end
            end else if (q.vref > target) begin
                if (q.vref - target > step) begin
                    d.vref = q.vref - step;
                end else begin
                    d.vref = target;
                end
            end
        end

        // input on/off hysteresis
        if (!q.run && vin_i >= q.words[IDX_VIN_START]) begin
            d.run = 1'b1;
        end else if (q.run && vin_i <= q.words[IDX_VIN_STOP]) begin
            d.run = 1'b0;
        end

        // over-voltage compare and current correction
        d.ov = vout_meas_i > q.words[IDX_OV_LIMIT];
        d.iout_corr = iout_raw_i + q.words[IDX_IOUT_OFS];
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                q.words[i] <= RST_WORDS[i];
            end
            q.reaction  <= RST_REACTION;
            q.strap_s1  <= '0;
            q.strap_s2  <= '0;
            q.strap     <= '0;
            q.strap_cnt <= '0;
            q.strap_ok  <= 1'b0;
            q.tick_cnt  <= '0;
            q.tick      <= 1'b0;
            q.vref      <= '0;
            q.iout_corr <= '0;
            q.run       <= 1'b0;
            q.ov        <= 1'b0;
            q.rsp       <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign rsp_o         = q.rsp;
    assign vout_ref_o    = q.vref;
    assign iout_corr_o   = q.iout_corr;
    assign conv_run_o    = q.run;
    assign ov_fault_o    = q.ov;
    assign ov_reaction_o = q.reaction;
    assign droop_o       = q.words[IDX_DROOP];
    assign loop_gain_o   = q.words[IDX_LOOP_GAIN];
    assign mon_scale_o   = q.words[IDX_MON_SCALE];
    assign duty_limit_o  = q.words[IDX_DUTY];
    assign fsw_o         = q.words[IDX_FSW];
    assign phase_group_o =
        q.words[IDX_PHASE][PHASE_GROUP_LSB +: PHASE_FIELD_W];
    assign phase_count_o =
        q.words[IDX_PHASE][PHASE_COUNT_LSB +: PHASE_FIELD_W];
    assign phase_pos_o   =
        q.words[IDX_PHASE][PHASE_POS_LSB +: PHASE_FIELD_W];

endmodule

/* logic/pob_pkg.sv */
package pob_pkg;

    // ==========================================================
    // widths and command codes
    localparam int NUM_WORDS = 17;
    typedef logic [7:0]  pob_code_t;
    typedef logic [15:0] pob_word_t;
    typedef logic [4:0]  pob_idx_t;

    localparam pob_code_t CMD_OUTPUT_SETPOINT         = 8'h21;
    localparam pob_code_t CMD_OUTPUT_TRIM             = 8'h22;
    localparam pob_code_t CMD_OUTPUT_CALIBRATION      = 8'h23;
    localparam pob_code_t CMD_OUTPUT_UPPER_BOUND      = 8'h24;
    localparam pob_code_t CMD_MARGIN_UP_TARGET        = 8'h25;
    localparam pob_code_t CMD_MARGIN_DOWN_TARGET      = 8'h26;
    localparam pob_code_t CMD_OUTPUT_SLEW_RATE        = 8'h27;
    localparam pob_code_t CMD_LOAD_LINE_SLOPE         = 8'h28;
    localparam pob_code_t CMD_SENSE_LOOP_GAIN         = 8'h29;
    localparam pob_code_t CMD_MONITOR_DIVIDER_SCALE   = 8'h2a;
    localparam pob_code_t CMD_DUTY_CYCLE_LIMIT        = 8'h32;
    localparam pob_code_t CMD_SWITCHING_RATE          = 8'h33;
    localparam pob_code_t CMD_INPUT_START_THRESHOLD   = 8'h35;
    localparam pob_code_t CMD_INPUT_STOP_THRESHOLD    = 8'h36;
    localparam pob_code_t CMD_PHASE_SPREAD_CONFIG     = 8'h37;
    localparam pob_code_t CMD_CURRENT_READING_OFFSET  = 8'h39;
    localparam pob_code_t CMD_OVERVOLTAGE_THRESHOLD   = 8'h40;
    localparam pob_code_t CMD_OVERVOLTAGE_REACTION    = 8'h41;

    // ==========================================================
    // storage indices
    localparam pob_idx_t IDX_SETPOINT  = 5'h00;
    localparam pob_idx_t IDX_TRIM      = 5'h01;
    localparam pob_idx_t IDX_CAL       = 5'h02;
    localparam pob_idx_t IDX_UPPER     = 5'h03;
    localparam pob_idx_t IDX_MARGIN_UP = 5'h04;
    localparam pob_idx_t IDX_MARGIN_DN = 5'h05;
    localparam pob_idx_t IDX_SLEW      = 5'h06;
    localparam pob_idx_t IDX_DROOP     = 5'h07;
    localparam pob_idx_t IDX_LOOP_GAIN = 5'h08;
    localparam pob_idx_t IDX_MON_SCALE = 5'h09;
    localparam pob_idx_t IDX_DUTY      = 5'h0a;
    localparam pob_idx_t IDX_FSW       = 5'h0b;
    localparam pob_idx_t IDX_VIN_START = 5'h0c;
    localparam pob_idx_t IDX_VIN_STOP  = 5'h0d;
    localparam pob_idx_t IDX_PHASE     = 5'h0e;
    localparam pob_idx_t IDX_IOUT_OFS  = 5'h0f;
    localparam pob_idx_t IDX_OV_LIMIT  = 5'h10;

    // ==========================================================
    // field positions
    localparam int PHASE_FIELD_W   = 4;
    localparam int PHASE_GROUP_LSB = 8;
    localparam int PHASE_COUNT_LSB = 4;
    localparam int PHASE_POS_LSB   = 0;
    localparam pob_word_t PHASE_MASK = 16'h0fff;
    localparam int FMT_SEL_LSB     = 5;
    localparam logic [2:0] FMT_LINEAR = 3'h0;
    localparam logic [7:0] OUT_FORMAT = 8'h17;

    // ==========================================================
    // values after reset
    localparam pob_word_t RST_WORDS [NUM_WORDS] = '{
        16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hffff};
    localparam logic [7:0] RST_REACTION = 8'h00;
    localparam int BOUND_NUM = 110;
    localparam int BOUND_DEN = 100;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLEW_TICK_NS  = 1000000;
    localparam int SLEW_TICK_CYC = SLEW_TICK_NS / CLK_PERIOD_NS;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // ==========================================================
    // carriers
    typedef enum logic [1:0] {
        MARGIN_NONE = 2'b00,
        MARGIN_UP   = 2'b01,
        MARGIN_DOWN = 2'b10
    } pob_margin_e;

    typedef struct packed {
        logic      valid;
        pob_code_t code;
        logic      write;
        logic      word;
        pob_word_t data;
    } pob_cmd_s;

    typedef struct packed {
        logic      valid;
        logic      err;
        pob_word_t data;
    } pob_rsp_s;

    typedef struct packed {
        logic      hit;
        pob_idx_t  idx;
        logic      is_byte;
        logic      read_only;
    } pob_dec_s;

endpackage

/* tb/pob_bank_properties.sv */
`timescale 1ns/1ns
module pob_bank_properties
    import pob_pkg::*;
(
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // command port
    input wire pob_cmd_s   cmd_i,
    input wire pob_rsp_s   rsp_o,
    // converter side
    input wire pob_word_t  vin_i,
    input wire pob_word_t  vout_meas_i,
    input wire logic       conv_run_o,
    input wire logic       ov_fault_o,
    input wire logic [7:0] ov_reaction_o,
    input wire logic [3:0] phase_group_o,
    input wire logic [3:0] phase_count_o,
    input wire logic [3:0] phase_pos_o
);
    // ==========================================================
    // decode helpers
    logic known;
    logic react;
    assign known = cmd_i.code inside {[8'h21:8'h2a], 8'h32, 8'h33,
                   8'h35, 8'h36, 8'h37, 8'h39, 8'h40, 8'h41};
    assign react = cmd_i.valid && cmd_i.code == CMD_OVERVOLTAGE_REACTION;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // properties
    AST_ANSWER: assert property (cmd_i.valid |=> rsp_o.valid)
        else $error("no answer");
    AST_STRAY: assert property (!cmd_i.valid |=> !rsp_o.valid)
        else $error("stray answer");
    AST_UNKNOWN: assert property (cmd_i.valid && !known
        |=> rsp_o.err) else $error("unknown code taken");
    AST_OFS_RO: assert property (cmd_i.valid && cmd_i.write &&
        cmd_i.code == CMD_CURRENT_READING_OFFSET |=> rsp_o.err)
        else $error("offset write taken");
    AST_REACT_WORD: assert property (react && cmd_i.word
        |=> rsp_o.err) else $error("reaction word taken");
    AST_REACT_SET: assert property (react && cmd_i.write &&
        !cmd_i.word |=> ov_reaction_o == $past(cmd_i.data[7:0]))
        else $error("reaction not stored");
    AST_REACT_RD: assert property (react && !cmd_i.write &&
        !cmd_i.word |=> rsp_o.data == {8'h00, ov_reaction_o})
        else $error("reaction read wrong");
    AST_PHASE: assert property (cmd_i.valid && cmd_i.write &&
        cmd_i.word && cmd_i.code == CMD_PHASE_SPREAD_CONFIG |=>
        {phase_group_o, phase_count_o, phase_pos_o}
        == $past(cmd_i.data[11:0])) else $error("phase fields wrong");
    AST_ERR_KEEP: assert property (rsp_o.valid && rsp_o.err
        |-> $stable(rsp_o.data)) else $error("refused read changed data");
    AST_OV_LOW: assert property (vout_meas_i == 16'h0
        |=> !ov_fault_o) else $error("fault at zero output");
    AST_RUN_STOP: assert property (conv_run_o && vin_i == 16'h0
        |=> !conv_run_o) else $error("run kept at zero input");
    AST_RUN_GO: assert property (!conv_run_o && vin_i == 16'hffff
        |=> conv_run_o) else $error("no start at full input");
endmodule
bind pob_output_config_bank pob_bank_properties u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .rsp_o(rsp_o),
    .vin_i(vin_i), .vout_meas_i(vout_meas_i), .conv_run_o(conv_run_o),
    .ov_fault_o(ov_fault_o), .ov_reaction_o(ov_reaction_o),
    .phase_group_o(phase_group_o), .phase_count_o(phase_count_o),
    .phase_pos_o(phase_pos_o));

/* tb/pob_host_model.sv */
`timescale 1ns/1ns
module pob_host_model
    import pob_pkg::*;
(
    // clock
    input  wire logic     clk_i,
    // command port
    output pob_cmd_s      cmd_o,
    input  wire pob_rsp_s rsp_i
);
    // ==========================================================
    // one command; released fields show inverted values
    initial cmd_o = '0;
    task automatic xfer(input pob_code_t c, input logic w, wd,
                        input pob_word_t d, output pob_rsp_s r);
        @(posedge clk_i);
        cmd_o <= '{1'b1, c, w, wd, d};
        @(posedge clk_i);
        cmd_o <= '{1'b0, ~c, ~w, ~wd, ~d};
        @(posedge clk_i);
        r = rsp_i;
    endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
module tb
    import pob_pkg::*;
;
    logic       clk_i, rst_n_i, trim_en_i, conv_run_o, ov_fault_o, run_m;
    logic [1:0] margin_i;
    logic [7:0] ov_reaction_o;
    logic [3:0] phase_group_o, phase_count_o, phase_pos_o;
    pob_word_t  strap_vout_i, vin_i, vout_meas_i, iout_raw_i, vout_ref_o;
    pob_word_t  iout_corr_o, droop_o, fsw_o, v, lim;
    pob_word_t  loop_gain_o, mon_scale_o, duty_limit_o, wx [17];
    pob_cmd_s   cmd_i;
    pob_rsp_s   rsp_o, r;
    int         err_total, check_count, cyc, n;
    integer     seed;
    pob_code_t  codes [17] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26,
        8'h27, 8'h28, 8'h29, 8'h2a, 8'h32, 8'h33, 8'h35, 8'h36, 8'h37,
        8'h39, 8'h40};
    pob_word_t  vins [6] = '{16'h2fff, 16'h3000, 16'h1001, 16'h0,
        16'hffff, 16'h1000};
    // ==========================================================
    // design, host and clock
    pob_output_config_bank #(.TICK_CYC(8)) DUT (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .cmd_i(cmd_i), .rsp_o(rsp_o),
        .strap_vout_i(strap_vout_i), .trim_en_i(trim_en_i),
        .margin_i(margin_i), .vin_i(vin_i), .vout_meas_i(vout_meas_i),
        .iout_raw_i(iout_raw_i), .vout_ref_o(vout_ref_o),
        .iout_corr_o(iout_corr_o), .conv_run_o(conv_run_o),
        .ov_fault_o(ov_fault_o), .ov_reaction_o(ov_reaction_o),
        .droop_o(droop_o), .loop_gain_o(loop_gain_o),
        .mon_scale_o(mon_scale_o), .duty_limit_o(duty_limit_o),
        .fsw_o(fsw_o), .phase_group_o(phase_group_o),
        .phase_count_o(phase_count_o), .phase_pos_o(phase_pos_o));
    pob_host_model u_host (.clk_i(clk_i), .cmd_o(cmd_i), .rsp_i(rsp_o));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // ==========================================================
    // helpers
    task automatic end_of_test();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input pob_word_t got, exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input pob_code_t c, input logic w, wd,
                       input pob_word_t d, input logic e);
        u_host.xfer(c, w, wd, d, r);
        chk({15'h0, r.err}, {15'h0, e});
    endtask
    function automatic pob_word_t exp_w(pob_code_t c, pob_word_t d);
        int m;
        m = int'(strap_vout_i) * BOUND_NUM / BOUND_DEN;
        if (c == CMD_PHASE_SPREAD_CONFIG) return d & PHASE_MASK;
        if (c == CMD_OUTPUT_UPPER_BOUND && int'(d) > m) return 16'(m);
        return d;
    endfunction
    function automatic pob_word_t tgt(pob_word_t b, t, c, u);
        int s;
        s = int'(b) + int'($signed(t)) + int'($signed(c));
        if (s < 0) return 16'h0;
        return (s > int'(u)) ? u : 16'(s);
    endfunction
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        seed = 32'h2e790c4c;
        {rst_n_i, trim_en_i, margin_i, vin_i, vout_meas_i} = '0;
        iout_raw_i = 16'h0;
        strap_vout_i = 16'h1000 | (16'($random(seed)) & 16'h0fff);
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        foreach (codes[i]) begin
            cmd(codes[i], 1'b0, 1'b1, 16'h0, 1'b0);
            chk(r.data, RST_WORDS[i]);
        end
        repeat (3) foreach (codes[i]) if (codes[i] != 8'h39) begin
            v = 16'($random(seed));
            wx[i] = exp_w(codes[i], v);
            cmd(codes[i], 1'b1, 1'b1, v, 1'b0);
            cmd(codes[i], 0, 1, 0, 0);
            chk(r.data, wx[i]);
        end
        chk(droop_o, wx[IDX_DROOP]);
        chk(loop_gain_o, wx[IDX_LOOP_GAIN]);
        chk(mon_scale_o, wx[IDX_MON_SCALE]);
        chk(duty_limit_o, wx[IDX_DUTY]);
        chk(fsw_o, wx[IDX_FSW]);
        cmd(CMD_PHASE_SPREAD_CONFIG, 1, 1, 16'hf5a0, 0);
        chk({4'h0, phase_group_o, phase_count_o, phase_pos_o},
            16'h05a0);
        cmd(CMD_CURRENT_READING_OFFSET, 1, 1, 16'h1234, 1);
        cmd(CMD_CURRENT_READING_OFFSET, 0, 0, 16'h0, 1);
        cmd(CMD_CURRENT_READING_OFFSET, 0, 1, 16'h0, 0);
        chk(r.data, 16'h0);
        cmd(8'h30, 0, 1, 16'h0, 1);
        cmd(CMD_OUTPUT_SETPOINT, 1, 0, 16'h0012, 1);
        cmd(CMD_OVERVOLTAGE_REACTION, 1, 1, 16'h0040, 1);
        v = 16'($random(seed));
        cmd(CMD_OVERVOLTAGE_REACTION, 1, 0, v, 0);
        cmd(CMD_OVERVOLTAGE_REACTION, 0, 0, 16'h0, 0);
        chk(r.data, {8'h0, v[7:0]});
        iout_raw_i <= 16'($random(seed));
        repeat (3) @(posedge clk_i);
        chk(iout_corr_o, iout_raw_i);
        cmd(CMD_INPUT_START_THRESHOLD, 1, 1, 16'h3000, 0);
        cmd(CMD_INPUT_STOP_THRESHOLD, 1, 1, 16'h1000, 0);
        run_m = 1'b0;
        foreach (vins[i]) begin
            vin_i <= vins[i];
            if (!run_m && vins[i] >= 16'h3000) run_m = 1'b1;
            else if (run_m && vins[i] <= 16'h1000) run_m = 1'b0;
            repeat (3) @(posedge clk_i);
            chk({15'h0, conv_run_o}, {15'h0, run_m});
        end
        cmd(CMD_OVERVOLTAGE_THRESHOLD, 1, 1, 16'h4000, 0);
        for (int k = 0; k < 2; k++) begin
            vout_meas_i <= 16'h4000 + 16'(k);
            repeat (3) @(posedge clk_i);
            chk({15'h0, ov_fault_o}, 16'(k));
        end
        cmd(CMD_OUTPUT_SLEW_RATE, 1, 1, 16'h0, 0);
        cmd(CMD_OUTPUT_UPPER_BOUND, 1, 1, 16'hffff, 0);
        lim = exp_w(CMD_OUTPUT_UPPER_BOUND, 16'hffff);
        cmd(CMD_OUTPUT_TRIM, 1, 1, 16'hff00, 0);
        cmd(CMD_OUTPUT_CALIBRATION, 1, 1, 16'h0010, 0);
        cmd(CMD_MARGIN_UP_TARGET, 1, 1, 16'h0900, 0);
        cmd(CMD_MARGIN_DOWN_TARGET, 1, 1, 16'h0700, 0);
        cmd(CMD_OUTPUT_SETPOINT, 1, 1, 16'h0800, 0);
        for (int k = 0; k < 4; k++) begin
            margin_i <= k[1:0];
            trim_en_i <= k[1];
            repeat (3) @(posedge clk_i);
            v = (k == 1) ? 16'h0900 : (k == 2) ? 16'h0700 : 16'h0800;
            v = tgt(v, k[1] ? 16'hff00 : 16'h0, 16'h10, lim);
            chk(vout_ref_o, v);
        end
        margin_i <= 2'b00;
        trim_en_i <= 1'b0;
        cmd(CMD_OUTPUT_SETPOINT, 1, 1, 16'hffff, 0);
        @(posedge clk_i);
        chk(vout_ref_o, lim);
        cmd(CMD_OUTPUT_SETPOINT, 1, 1, 16'h0810, 0);
        cmd(CMD_OUTPUT_SLEW_RATE, 1, 1, 16'h0008, 0);
        cmd(CMD_OUTPUT_SETPOINT, 1, 1, 16'h0830, 0);
        n = 0;
        while (vout_ref_o !== 16'h0840 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        chk(16'(n >= 25 && n <= 32), 16'h1);
        end_of_test();
    end
endmodule
